// [src/csr_pkg.sv]
// package: register offsets, field positions, reset values, bus types for the charger status bank
package csr_pkg;
	// i2c target address, 7-bit and 8-bit shifted form
	localparam logic [6:0] CSR_I2C_ADDR = 7'h6B;
	localparam logic [7:0] CSR_I2C_ADDR_W8 = 8'hD6;
	// register offsets
	localparam logic [7:0] CSR_OFS_CHARGER_STATUS_0 = 8'h00;
	localparam logic [7:0] CSR_OFS_CHARGER_STATUS_1 = 8'h01;
	localparam logic [7:0] CSR_OFS_GENERAL_STATUS_2 = 8'h02;
	localparam logic [7:0] CSR_OFS_CHARGER_EVENT_FLAGS_0 = 8'h03;
	localparam logic [7:0] CSR_OFS_CHARGER_EVENT_FLAGS_1 = 8'h04;
	localparam logic [7:0] CSR_OFS_EVENT_FLAGS_2 = 8'h05;
	localparam logic [7:0] CSR_OFS_TIMER_EVENT_FLAGS = 8'h06;
	localparam logic [7:0] CSR_OFS_INTERRUPT_MASK_0 = 8'h07;
	localparam logic [7:0] CSR_OFS_INTERRUPT_MASK_3 = 8'h0A;
	localparam logic [7:0] CSR_OFS_DEVID = 8'h6F;
	localparam int CSR_NUM_RW = 22;
	localparam logic [7:0] CSR_RW_OFS [CSR_NUM_RW] = '{
		8'h07, 8'h08, 8'h09, 8'h0A, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18,
		8'h19, 8'h1D, 8'h30, 8'h35, 8'h36, 8'h37, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65};
	// field positions, status 0
	localparam int CSR_S0_TAPER = 6;
	localparam int CSR_S0_DONE = 5;
	localparam int CSR_S0_ILIM = 4;
	localparam int CSR_S0_DYNAMIC_POWER_PATH_MANAGEMENT = 3;
	localparam int CSR_S0_VDPM = 2;
	localparam int CSR_S0_THERM = 1;
	localparam int CSR_S0_PGOOD = 0;
	// field positions, status 1 and event flags 0
	localparam int CSR_S1_OVP = 7;
	localparam int CSR_S1_OCP = 5;
	localparam int CSR_S1_BUV = 4;
	localparam int CSR_S1_COLD = 3;
	localparam int CSR_S1_COOL = 2;
	localparam int CSR_S1_WARM = 1;
	localparam int CSR_S1_HOT = 0;
	localparam int CSR_F0_PGOOD = 0;
	// reset and fixed values
	localparam logic [7:0] CSR_RST_RW = 8'h00;
	localparam logic [7:0] CSR_RST_FLAG = 8'h00;
	localparam logic [7:0] CSR_RSVD_VAL = 8'h00;
	localparam logic [7:0] CSR_UNMAPPED_RD = 8'h00;
	// arbitrary identification value
	localparam logic [7:0] CSR_DEVID_VAL = 8'h5A;
	// analog conditions fed in from the charger core
	typedef struct packed {
		logic taper_phase_active;
		logic charge_done_active;
		logic input_limit_loop_active;
		logic power_path_loop_active;
		logic input_voltage_loop_active;
		logic die_thermal_loop_active;
		logic vin_above_uvlo;
		logic vin_above_bat_sleep_margin;
		logic vin_below_ovp;
		logic input_overvoltage_active;
		logic battery_overcurrent_active;
		logic battery_low_lockout_active;
		logic thermistor_cold_region;
		logic thermistor_cool_region;
		logic thermistor_warm_region;
		logic thermistor_hot_region;
		logic thermistor_open;
	} csr_cond_t;
	// register access from the i2c target
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} csr_req_t;
endpackage

// [src/csr_sync_stage.sv]
// module: one-cycle registration of the live condition inputs
`timescale 1ns/1ns
`default_nettype none
module csr_sync_stage
	import csr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire csr_pkg::csr_cond_t cond_i,
	output csr_pkg::csr_cond_t cond_o
);
	// inputs are synchronous; one stage keeps status and flag timing aligned
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cond_o <= '0;
		end else begin
			cond_o <= cond_i;
		end
	end
endmodule
`default_nettype wire

// [src/csr_i2c_target.sv]
// module: i2c target front end with register pointer, auto-incrementing multi-byte accesses
`timescale 1ns/1ns
`default_nettype none
module csr_i2c_target
	import csr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_oe_o,
	output csr_pkg::csr_req_t req_o,
	input wire logic [7:0] rdata_i
);
	typedef enum logic [2:0] {
		CSR_ST_IDLE = 3'b000,
		CSR_ST_ADDR = 3'b001,
		CSR_ST_ACK = 3'b010,
		CSR_ST_WBYTE = 3'b011,
		CSR_ST_RBYTE = 3'b100,
		CSR_ST_RACK = 3'b101
	} csr_i2c_st_t;
	csr_i2c_st_t state_reg;
	logic scl_q, sda_q;
	logic [7:0] shift_reg;
	logic [3:0] cnt_reg;
	logic rnw_reg, ptr_phase_reg;
	logic [7:0] ptr_reg;
	logic scl_rise, scl_fall, start_c, stop_c;
	assign scl_rise = scl_i & ~scl_q;
	assign scl_fall = ~scl_i & scl_q;
	assign start_c = scl_i & scl_q & sda_q & ~sda_i;
	assign stop_c = scl_i & scl_q & ~sda_q & sda_i;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= CSR_ST_IDLE;
			shift_reg <= 8'h00;
			cnt_reg <= 4'h0;
			rnw_reg <= 1'b0;
			ptr_phase_reg <= 1'b0;
			ptr_reg <= 8'h00;
			sda_oe_o <= 1'b0;
			req_o <= '0;
		end else begin
			req_o.wr <= 1'b0;
			req_o.rd <= 1'b0;
			if (start_c) begin
				state_reg <= CSR_ST_ADDR;
				cnt_reg <= 4'h0;
				sda_oe_o <= 1'b0;
			end else if (stop_c) begin
				state_reg <= CSR_ST_IDLE;
				sda_oe_o <= 1'b0;
			end else begin
				case (state_reg)
				CSR_ST_ADDR: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_i};
						cnt_reg <= cnt_reg + 4'h1;
					end
					if (scl_fall && cnt_reg == 4'h8) begin
						if (shift_reg[7:1] == CSR_I2C_ADDR) begin
							rnw_reg <= shift_reg[0];
							ptr_phase_reg <= ~shift_reg[0];
							sda_oe_o <= 1'b1;
							state_reg <= CSR_ST_ACK;
							if (shift_reg[0]) begin
								req_o.rd <= 1'b1;
								req_o.addr <= ptr_reg;
							end
						end else begin
							state_reg <= CSR_ST_IDLE;
						end
					end
				end
				CSR_ST_ACK: begin
					if (scl_fall) begin
						cnt_reg <= 4'h0;
						if (rnw_reg) begin
							shift_reg <= rdata_i;
							sda_oe_o <= ~rdata_i[7];
							state_reg <= CSR_ST_RBYTE;
						end else begin
							sda_oe_o <= 1'b0;
							state_reg <= CSR_ST_WBYTE;
						end
					end
				end
				CSR_ST_WBYTE: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_i};
						cnt_reg <= cnt_reg + 4'h1;
					end
					if (scl_fall && cnt_reg == 4'h8) begin
						sda_oe_o <= 1'b1;
						state_reg <= CSR_ST_ACK;
						if (ptr_phase_reg) begin
							ptr_reg <= shift_reg;
							ptr_phase_reg <= 1'b0;
						end else begin
							req_o.wr <= 1'b1;
							req_o.addr <= ptr_reg;
							req_o.wdata <= shift_reg;
							ptr_reg <= ptr_reg + 8'h01;
						end
					end
				end
				CSR_ST_RBYTE: begin
					if (scl_fall) begin
						cnt_reg <= cnt_reg + 4'h1;
						if (cnt_reg == 4'h7) begin
							sda_oe_o <= 1'b0;
							state_reg <= CSR_ST_RACK;
						end else begin
							sda_oe_o <= ~shift_reg[6];
							shift_reg <= {shift_reg[6:0], 1'b0};
						end
					end
				end
				CSR_ST_RACK: begin
					// host nack ends the read; ack fetches the next byte
					if (scl_rise) begin
						if (sda_i) begin
							state_reg <= CSR_ST_IDLE;
						end else begin
							ptr_reg <= ptr_reg + 8'h01;
							req_o.rd <= 1'b1;
							req_o.addr <= ptr_reg + 8'h01;
							state_reg <= CSR_ST_ACK;
						end
					end
				end
				default: begin
					state_reg <= CSR_ST_IDLE;
				end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// [src/csr_bank.sv]
// module: charger status register bank behind an i2c target
//
// Operation
// - answers as i2c target at 7-bit address 0x6B, shifted 0xD6
// - both charger status registers are read only and reset to 0x00
// - status 0 bit 6 shows constant-voltage taper phase
// - status 0 bit 5 shows charge termination active
// - status 0 bit 4 shows input current limit loop active
// - status 0 bit 3 shows power path management reducing charge current
// - status 0 bit 2 shows input voltage management active
// - status 0 bit 1 shows thermal regulation active
// - status 0 bit 0 set only when input above lockout, sleep margin, below overvoltage
// - status 1 bit 7 shows input overvoltage
// - status 1 bit 5 shows battery overcurrent protection
// - status 1 bit 4 shows battery below lockout threshold
// - status 1 bit 3 shows thermistor cold region
// - status 1 bit 2 shows thermistor cool region
// - status 1 bit 1 shows thermistor warm region
// - status 1 bit 0 shows thermistor hot region
// - status registers at offsets 0 and 1 reflect present conditions
// - power-good change flag latches on any change, clears when read
`timescale 1ns/1ns
`default_nettype none
module csr_bank
	import csr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire csr_pkg::csr_cond_t cond_i,
	output logic [7:0] charger_status_0_o,
	output logic [7:0] charger_status_1_o,
	output logic [7:0] charger_event_flags_0_o,
	output logic [7:0] ctrl_reg_o [CSR_NUM_RW]
);
	import csr_pkg::*;

	// ----------------------------------------------------------------
	// decoding helpers
	// ----------------------------------------------------------------
	function automatic int rw_index(input logic [7:0] a);
		int k;
		k = -1;
		for (int i = 0; i < CSR_NUM_RW; i++) begin
			if (CSR_RW_OFS[i] == a) begin
				k = i;
			end
		end
		return k;
	endfunction

	// ----------------------------------------------------------------
	// live conditions and i2c front end
	// ----------------------------------------------------------------
	csr_cond_t cond_q;
	csr_req_t req;
	logic [7:0] rdata_next;
	logic [7:0] rdata_reg;
	logic [7:0] charger_status_0_next, charger_status_1_next, general_status_2_next;
	logic pgood_q;
	logic pgood_seen_reg;

	csr_sync_stage u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cond_i(cond_i),
		.cond_o(cond_q)
	);

	csr_i2c_target u_i2c (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_oe_o(sda_oe_o),
		.req_o(req),
		.rdata_i(rdata_reg)
	);

	// open drain: only ever drives low
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sda_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// status composition
	// ----------------------------------------------------------------
	always_comb begin
		charger_status_0_next = CSR_RSVD_VAL;
		charger_status_1_next = CSR_RSVD_VAL;
		general_status_2_next = CSR_RSVD_VAL;
		charger_status_0_next[CSR_S0_TAPER] = cond_q.taper_phase_active;
		charger_status_0_next[CSR_S0_DONE] = cond_q.charge_done_active;
		charger_status_0_next[CSR_S0_ILIM] = cond_q.input_limit_loop_active;
		charger_status_0_next[CSR_S0_DYNAMIC_POWER_PATH_MANAGEMENT] = cond_q.power_path_loop_active;
		charger_status_0_next[CSR_S0_VDPM] = cond_q.input_voltage_loop_active;
		charger_status_0_next[CSR_S0_THERM] = cond_q.die_thermal_loop_active;
		charger_status_0_next[CSR_S0_PGOOD] = cond_q.vin_above_uvlo & cond_q.vin_above_bat_sleep_margin
			& cond_q.vin_below_ovp;
		charger_status_1_next[CSR_S1_OVP] = cond_q.input_overvoltage_active;
		charger_status_1_next[CSR_S1_OCP] = cond_q.battery_overcurrent_active;
		charger_status_1_next[CSR_S1_BUV] = cond_q.battery_low_lockout_active;
		charger_status_1_next[CSR_S1_COLD] = cond_q.thermistor_cold_region;
		charger_status_1_next[CSR_S1_COOL] = cond_q.thermistor_cool_region;
		charger_status_1_next[CSR_S1_WARM] = cond_q.thermistor_warm_region;
		charger_status_1_next[CSR_S1_HOT] = cond_q.thermistor_hot_region;
		general_status_2_next[0] = cond_q.thermistor_open;
	end

	// status held only by the live sampling, never written
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			charger_status_0_o <= 8'h00;
			charger_status_1_o <= 8'h00;
		end else begin
			charger_status_0_o <= charger_status_0_next;
			charger_status_1_o <= charger_status_1_next;
		end
	end

	// ----------------------------------------------------------------
	// power-good change flag
	// ----------------------------------------------------------------
	// first sample after reset is not counted as a change
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pgood_q <= 1'b0;
			pgood_seen_reg <= 1'b0;
		end else begin
			pgood_q <= charger_status_0_next[CSR_S0_PGOOD];
			pgood_seen_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			charger_event_flags_0_o <= CSR_RST_FLAG;
		end else begin
			// set wins over clear on read
			if (pgood_seen_reg && (pgood_q != charger_status_0_next[CSR_S0_PGOOD])) begin
				charger_event_flags_0_o[CSR_F0_PGOOD] <= 1'b1;
			end else if (req.rd && req.addr == CSR_OFS_CHARGER_EVENT_FLAGS_0) begin
				charger_event_flags_0_o[CSR_F0_PGOOD] <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// writable settings
	// ----------------------------------------------------------------
	// only listed writable offsets accept data; status and unlisted drop it
	genvar g;
	generate
		for (g = 0; g < CSR_NUM_RW; g++) begin : g_rw
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					ctrl_reg_o[g] <= CSR_RST_RW;
				end else if (req.wr && req.addr == CSR_RW_OFS[g]) begin
					ctrl_reg_o[g] <= req.wdata;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		int k;
		k = rw_index(req.addr);
		rdata_next = CSR_UNMAPPED_RD;
		if (req.addr == CSR_OFS_CHARGER_STATUS_0) begin
			rdata_next = charger_status_0_next;
		end else if (req.addr == CSR_OFS_CHARGER_STATUS_1) begin
			rdata_next = charger_status_1_next;
		end else if (req.addr == CSR_OFS_GENERAL_STATUS_2) begin
			rdata_next = general_status_2_next;
		end else if (req.addr == CSR_OFS_CHARGER_EVENT_FLAGS_0) begin
			rdata_next = charger_event_flags_0_o;
		end else if (req.addr == CSR_OFS_DEVID) begin
			rdata_next = CSR_DEVID_VAL;
		end else if (k >= 0) begin
			// unlisted offsets fall through to the fixed value
			rdata_next = ctrl_reg_o[k];
		end
	end

	// byte held at fetch, same edge as the read clear
	// front end loads it several clocks later; a live mux would lose the flag
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= 8'h00;
		end else if (req.rd) begin
			rdata_reg <= rdata_next;
		end
	end
endmodule
`default_nettype wire

// [dv/csr_bank_asserts.sv]
// checker: status, flag and pin relations of the charger status bank
`timescale 1ns/1ns
`default_nettype none
module csr_bank_asserts
	import csr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire csr_pkg::csr_cond_t cond_i,
	input wire logic [7:0] charger_status_0_o,
	input wire logic [7:0] charger_status_1_o,
	input wire logic [7:0] charger_event_flags_0_o
);
	logic [2:0] up_reg;
	logic live;
	logic [7:0] s0;
	logic [7:0] s1;
	csr_cond_t c;
	assign s0 = charger_status_0_o;
	assign s1 = charger_status_1_o;
	assign c = cond_i;
	// ----------------------------------------
	// status lags cond by two cycles, so wait out the pipe after reset
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			up_reg <= 3'h0;
		end else if (!live) begin
			up_reg <= up_reg + 3'h1;
		end
	end
	assign live = (up_reg == 3'h7);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence pg_moved;
		live && $changed(s0[0]);
	endsequence
	a_taper_bit: assert property (live |-> s0[6] == $past(c.taper_phase_active, 2))
		else $error("taper bit wrong");
	a_done_bit: assert property (live |-> s0[5] == $past(c.charge_done_active, 2))
		else $error("done bit wrong");
	a_loop_bits: assert property (live |-> s0[4:1] == $past({
		c.input_limit_loop_active, c.power_path_loop_active,
		c.input_voltage_loop_active, c.die_thermal_loop_active}, 2)) else $error("loop bits wrong");
	a_pgood_bit: assert property (live |-> s0[0] == $past(c.vin_above_uvlo
		& c.vin_above_bat_sleep_margin & c.vin_below_ovp, 2)) else $error("power good wrong");
	a_fault_bits: assert property (live |-> {s1[7], s1[5:4]} == $past({
		c.input_overvoltage_active, c.battery_overcurrent_active,
		c.battery_low_lockout_active}, 2)) else $error("fault bits wrong");
	a_region_bits: assert property (live |-> s1[3:0] == $past({
		c.thermistor_cold_region, c.thermistor_cool_region,
		c.thermistor_warm_region, c.thermistor_hot_region}, 2)) else $error("region bits wrong");
	a_rsvd_zero: assert property (!s0[7] && !s1[6])
		else $error("reserved bit set");
	a_flag_set: assert property (pg_moved |-> ##[0:3] charger_event_flags_0_o[0])
		else $error("power good flag not set");
	a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("sda drive moved with scl high");
	a_sda_low_only: assert property (!sda_o)
		else $error("sda driven high");
endmodule
bind csr_bank csr_bank_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i),
	.sda_o(sda_o), .sda_oe_o(sda_oe_o), .cond_i(cond_i),
	.charger_status_0_o(charger_status_0_o),
	.charger_status_1_o(charger_status_1_o),
	.charger_event_flags_0_o(charger_event_flags_0_o));
`default_nettype wire

// [dv/csr_i2c_host.sv]
// partner: behavioural i2c host driving the bank's bus pins
`timescale 1ns/1ns
`default_nettype none
module csr_i2c_host
	import csr_pkg::*;
(
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o,
	output logic rd_valid_o,
	output logic [7:0] rd_data_o
);
	// quarter scl period; the bank needs several clocks per phase
	localparam int QTR = 4;
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
		rd_valid_o = 1'b0;
		rd_data_o = 8'h00;
	end
	// ----------------------------------------
	// bus steps: only one wire moves per step
	// ----------------------------------------
	task automatic step(input logic ck, input logic low);
		scl_o = ck;
		sda_low_o = low;
		repeat (QTR) @(posedge clk_i);
		#1;
	endtask
	task automatic bit_io(input logic b, output logic s);
		step(1'b0, !b);
		step(1'b1, !b);
		s = sda_i;
		step(1'b1, !b);
		step(1'b0, !b);
	endtask
	task automatic start();
		step(scl_o, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
		step(1'b0, 1'b1);
	endtask
	task automatic stop();
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
	endtask
	task automatic tx(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], ack);
		end
		bit_io(1'b1, ack);
	endtask
	// one data byte written, or n bytes read from the pointer on
	task automatic xfer(input logic [7:0] ofs, input logic w, input logic [7:0] d, input int n);
		logic a;
		logic [7:0] q;
		start();
		tx(CSR_I2C_ADDR_W8, a);
		tx(ofs, a);
		if (w) begin
			tx(d, a);
		end else begin
			start();
			tx(CSR_I2C_ADDR_W8 | 8'h01, a);
			for (int k = 0; k < n; k++) begin
				for (int i = 7; i >= 0; i--) begin
					bit_io(1'b1, q[i]);
				end
				bit_io(k == n - 1, a);
				rd_data_o = q;
				rd_valid_o = 1'b1;
				@(posedge clk_i);
				#1;
				rd_valid_o = 1'b0;
			end
		end
		stop();
	endtask
endmodule
`default_nettype wire

// [dv/csr_bank_tb_top.sv]
// testbench: i2c host against the charger status bank
`timescale 1ns/1ns
`default_nettype none
module csr_bank_tb_top;
	import csr_pkg::*;
	logic clk, rst, scl, sda_low, sda, sda_oe, rd_valid, ack, pg, fexp;
	logic [7:0] rd_data, s0, s1, flg, d, e;
	logic [7:0] ctrl [CSR_NUM_RW];
	logic [31:0] r;
	csr_cond_t cond;
	int num_errors = 0;
	int compares = 0;
	int cyc = 0;
	int i;
	logic [7:0] exp_q [$];
	// open drain wire with pull-up
	assign sda = !sda_oe && !sda_low;
	csr_bank uut (.clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(),
		.sda_oe_o(sda_oe), .cond_i(cond), .charger_status_0_o(s0), .charger_status_1_o(s1),
		.charger_event_flags_0_o(flg), .ctrl_reg_o(ctrl));
	csr_i2c_host u_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low),
		.rd_valid_o(rd_valid), .rd_data_o(rd_data));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	function automatic logic [7:0] e0(input csr_cond_t c);
		return {1'b0, c.taper_phase_active, c.charge_done_active, c.input_limit_loop_active,
			c.power_path_loop_active, c.input_voltage_loop_active, c.die_thermal_loop_active,
			c.vin_above_uvlo & c.vin_above_bat_sleep_margin & c.vin_below_ovp};
	endfunction
	function automatic logic [7:0] e1(input csr_cond_t c);
		return {c.input_overvoltage_active, 1'b0, c.battery_overcurrent_active,
			c.battery_low_lockout_active, c.thermistor_cold_region, c.thermistor_cool_region,
			c.thermistor_warm_region, c.thermistor_hot_region};
	endfunction
	task automatic chk(input string what, input logic [7:0] ex, input logic [7:0] got);
		compares++;
		if (got !== ex) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, ex, got);
		end
	endtask
	task automatic stop_test();
		chk("pending notes", 8'h00, 8'(exp_q.size()));
		if (num_errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ----------------------------------------
	// monitor: each read byte meets the oldest note
	// ----------------------------------------
	always @(posedge clk) begin
		if (rd_valid === 1'b1) begin
			chk("read byte", exp_q.pop_front(), rd_data);
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			stop_test();
		end
	end
	initial begin
		void'($urandom(32'hF46AC9E7));
		rst = 1'b1;
		cond = '0;
		pg = 1'b0;
		fexp = 1'b0;
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		for (i = 0; i < CSR_NUM_RW; i++) begin
			chk("setting reset", CSR_RST_RW, ctrl[i]);
		end
		for (i = 0; i < 2; i++) begin
			u_host.start();
			u_host.tx(i ? 8'hD6 : 8'hD4, ack);
			u_host.stop();
			chk("address ack", {7'h0, ~i[0]}, {7'h0, ack});
		end
		// all ones, all zeros, then random conditions
		for (int n = 0; n < 12; n++) begin
			r = $urandom;
			cond = r[$bits(csr_cond_t)-1:0];
			if (n < 2) cond = n ? '0 : '1;
			repeat (3) @(posedge clk);
			#1;
			e = e0(cond);
			chk("status 0", e, s0);
			chk("status 1", e1(cond), s1);
			fexp = fexp | (e[0] != pg);
			pg = e[0];
			if (n == 5) begin
				u_host.xfer(CSR_OFS_CHARGER_STATUS_0, 1'b1, 8'hFF, 1);
				u_host.xfer(CSR_OFS_CHARGER_STATUS_1, 1'b1, 8'hFF, 1);
			end
			exp_q.push_back(e);
			exp_q.push_back(e1(cond));
			exp_q.push_back({7'h0, cond.thermistor_open});
			exp_q.push_back({7'h0, fexp});
			u_host.xfer(CSR_OFS_CHARGER_STATUS_0, 1'b0, 8'h00, 4);
			fexp = 1'b0;
			chk("flag port", 8'h00, flg);
		end
		for (int n = 0; n < 4; n++) begin
			i = $urandom_range(CSR_NUM_RW - 1);
			d = 8'($urandom);
			u_host.xfer(CSR_RW_OFS[i], 1'b1, d, 1);
			chk("setting port", d, ctrl[i]);
			exp_q.push_back(d);
			u_host.xfer(CSR_RW_OFS[i], 1'b0, 8'h00, 1);
		end
		exp_q.push_back(CSR_DEVID_VAL);
		exp_q.push_back(CSR_UNMAPPED_RD);
		u_host.xfer(CSR_OFS_DEVID, 1'b0, 8'h00, 2);
		stop_test();
	end
endmodule
`default_nettype wire
